// [gpio_port_pkg.sv]
// constants shared by the gpio port, its interrupt groups and its bus slave
// Overview of operation
// - eight pins, bit x of the value, direction and option registers controls and reflects pin x
// - direction clear makes an input; data reads return the pin level
// - data writes on input pins only update the latch, pin unchanged
// - option bit picks floating or pull-up input; pull-up input also interrupts on interrupt pins
// - direction set drives latch onto pin; data reads return the latch
// - output option picks push-pull or open-drain; latch 0 drives low always
// - interrupt input raises a request on an event matching its sensitivity
// - each pin detected by group sensitivity, then group detections ored
// - request latch hidden from software, cleared by vector fetch
// - any write of a group's sensitivity drops its pending request
// - enabled peripheral function overrides register-based pin configuration
// - peripheral output forces output mode, push-pull or open-drain per peripheral
// - peripheral input pins are inputs in software; level still readable
// - input config with peripheral output: data read returns peripheral value
// - output config with peripheral input: peripheral receives the latch value
// - direction/option: 00 floating, 01 pull-up, 10 open-drain, 11 push-pull
// - on interrupt pins 01 means input with interrupt, 00 plain floating
package gpio_port_pkg;
   localparam int PINS = 8;
   localparam int GROUPS = 2;
   localparam int SENS_W = 2;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] PIN_VALUE_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] DIRECTION_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] OPTION_OFS = 12'h008;
   localparam logic [ADDR_W-1:0] SENSITIVITY_OFS = 12'h00c;
   localparam logic [PINS-1:0] PORT_RESET = 8'h00;
   localparam logic [SENS_W-1:0] SENS_RESET = 2'h0;
   localparam logic [SENS_W-1:0] SENS_LOW_LEVEL = 2'h0;
   localparam logic [SENS_W-1:0] SENS_RISING = 2'h1;
   localparam logic [SENS_W-1:0] SENS_FALLING = 2'h2;
   localparam logic [SENS_W-1:0] SENS_BOTH = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {REG_PIN_VALUE, REG_DIRECTION, REG_OPTION, REG_SENSITIVITY,
                             REG_NONE} reg_sel_type;
endpackage

// [pin_sync.sv]
// two-stage synchroniser for the pad inputs
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// [ext_irq_group.sv]
// one external interrupt vector: per-pin detection, or, and request latch
`timescale 1ns/10ps
module ext_irq_group
   import gpio_port_pkg::*;
#(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // synchronised pins and their interrupt enables
   input wire logic [WIDTH-1:0] pin_level,
   input wire logic [WIDTH-1:0] irq_en,
   // sensitivity
   input wire logic [gpio_port_pkg::SENS_W-1:0] sens,
   input wire logic sens_wr,
   // processor side
   input wire logic vector_fetch,
   output logic irq_req
);
   logic [WIDTH-1:0] prev_q;
   logic [WIDTH-1:0] hit;
   logic any_hit;
   logic req_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= '0;
      else
         prev_q <= pin_level;
   end

   always_comb
   begin
      unique case (sens)
         SENS_LOW_LEVEL: hit = irq_en & ~pin_level;
         SENS_RISING: hit = irq_en & pin_level & ~prev_q;
         SENS_FALLING: hit = irq_en & ~pin_level & prev_q;
         SENS_BOTH: hit = irq_en & (pin_level ^ prev_q);
      endcase
   end

   assign any_hit = |hit;

   // a fresh event beats a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         req_q <= 1'b0;
      else if (any_hit)
         req_q <= 1'b1;
      else if (vector_fetch || sens_wr)
         req_q <= 1'b0;
   end

   assign irq_req = req_q;
endmodule

// [gpio_port.sv]
// gpio port top: pin muxing, port registers and axi4-lite slave
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module gpio_port
   import gpio_port_pkg::*;
#(
   parameter int NPINS = gpio_port_pkg::PINS,
   parameter int NGROUPS = gpio_port_pkg::GROUPS,
   parameter logic [gpio_port_pkg::PINS-1:0] IRQ_PIN_MASK = 8'hff
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [gpio_port_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [gpio_port_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [gpio_port_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [gpio_port_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // pads
   input wire logic [gpio_port_pkg::PINS-1:0] pad_in,
   output logic [gpio_port_pkg::PINS-1:0] pad_out,
   output logic [gpio_port_pkg::PINS-1:0] pad_oe,
   output logic [gpio_port_pkg::PINS-1:0] pad_pullup_en,
   // on-chip peripheral functions
   input wire logic [gpio_port_pkg::PINS-1:0] alt_out_en,
   input wire logic [gpio_port_pkg::PINS-1:0] alt_out_val,
   input wire logic [gpio_port_pkg::PINS-1:0] alt_open_drain,
   output logic [gpio_port_pkg::PINS-1:0] alt_in,
   // external interrupt vectors
   input wire logic [gpio_port_pkg::GROUPS-1:0] irq_vector_fetch,
   output logic [gpio_port_pkg::GROUPS-1:0] irq_req
);
   import gpio_port_pkg::*;

   localparam int GROUP_W = NPINS / NGROUPS;
   localparam int SENS_BITS = NGROUPS * SENS_W;

   // port registers
   logic [NPINS-1:0] latch_q;
   logic [NPINS-1:0] dir_q;
   logic [NPINS-1:0] opt_q;
   logic [SENS_BITS-1:0] sens_q;
   logic [NPINS-1:0] pin_level;
   logic [NPINS-1:0] read_value;
   logic [NPINS-1:0] irq_en;

   // bus slave state
   logic aw_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic w_held_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;
   logic do_write;
   logic do_read;
   logic byte0_wr;
   reg_sel_type wr_sel;
   reg_sel_type rd_sel;

   // shared by the write and the read path
   function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
      reg_sel_type sel;
      sel = REG_NONE;
      unique case (addr)
         PIN_VALUE_OFS: sel = REG_PIN_VALUE;
         DIRECTION_OFS: sel = REG_DIRECTION;
         OPTION_OFS: sel = REG_OPTION;
         SENSITIVITY_OFS: sel = REG_SENSITIVITY;
         default: sel = REG_NONE;
      endcase
      return sel;
   endfunction

   // pad inputs are asynchronous to clk
   pin_sync #(
      .WIDTH(NPINS)
   ) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(pad_in),
      .sync_out(pin_level)
   );

   // write channel acceptance, either order
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign wr_sel = decode(awaddr_q);
   assign byte0_wr = do_write && wstrb_q[0];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         w_held_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
         w_held_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // port registers; the latch is written whatever the direction
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         latch_q <= PORT_RESET;
      else if (byte0_wr && wr_sel == REG_PIN_VALUE)
         latch_q <= wdata_q[NPINS-1:0];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dir_q <= PORT_RESET;
      else if (byte0_wr && wr_sel == REG_DIRECTION)
         dir_q <= wdata_q[NPINS-1:0];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         opt_q <= PORT_RESET;
      else if (byte0_wr && wr_sel == REG_OPTION)
         opt_q <= wdata_q[NPINS-1:0];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sens_q <= {NGROUPS{SENS_RESET}};
      else if (byte0_wr && wr_sel == REG_SENSITIVITY)
         sens_q <= wdata_q[SENS_BITS-1:0];
   end

   // per-pin mode, peripheral function first
   always_comb
   begin
      for (int i = 0; i < NPINS; i++)
      begin
         if (alt_out_en[i])
         begin
            // open-drain peripheral output releases on a one
            pad_out[i] = alt_open_drain[i] ? 1'b0 : alt_out_val[i];
            pad_oe[i] = alt_open_drain[i] ? !alt_out_val[i] : 1'b1;
            pad_pullup_en[i] = 1'b0;
            read_value[i] = dir_q[i] ? latch_q[i] : alt_out_val[i];
         end
         else if (dir_q[i])
         begin
            // 10 open-drain, 11 push-pull
            pad_out[i] = opt_q[i] ? latch_q[i] : 1'b0;
            pad_oe[i] = opt_q[i] ? 1'b1 : !latch_q[i];
            pad_pullup_en[i] = 1'b0;
            read_value[i] = latch_q[i];
         end
         else
         begin
            // 00 floating, 01 pull-up
            pad_out[i] = 1'b0;
            pad_oe[i] = 1'b0;
            pad_pullup_en[i] = opt_q[i];
            read_value[i] = pin_level[i];
         end
      end
   end

   // peripheral inputs see the latch when the pin is an output
   always_comb
   begin
      for (int i = 0; i < NPINS; i++)
         alt_in[i] = dir_q[i] ? latch_q[i] : pin_level[i];
   end

   // interrupt input: direction 0, option 1, interrupt-capable pin;
   // a driving peripheral masks it so its own toggling cannot fire requests
   always_comb
   begin
      for (int i = 0; i < NPINS; i++)
         irq_en[i] = IRQ_PIN_MASK[i] && !dir_q[i] && opt_q[i] && !alt_out_en[i];
   end

   // one vector per group of adjacent pins
   genvar g;
   generate
      for (g = 0; g < NGROUPS; g++)
      begin : grp
         ext_irq_group #(
            .WIDTH(GROUP_W)
         ) u_group (
            .clk(clk),
            .rst_n(rst_n),
            .pin_level(pin_level[g*GROUP_W +: GROUP_W]),
            .irq_en(irq_en[g*GROUP_W +: GROUP_W]),
            .sens(sens_q[g*SENS_W +: SENS_W]),
            .sens_wr(byte0_wr && wr_sel == REG_SENSITIVITY),
            .vector_fetch(irq_vector_fetch[g]),
            .irq_req(irq_req[g])
         );
      end
   endgenerate

   // read channel; data captured from the registers and synchronised pin levels at the accepting edge
   assign s_axi_arready = !rvalid_q;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign rd_sel = decode(s_axi_araddr);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rvalid_q <= 1'b0;
      else if (do_read)
         rvalid_q <= 1'b1;
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end
      else if (do_read)
      begin
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
         unique case (rd_sel)
            REG_PIN_VALUE: rdata_q[NPINS-1:0] <= read_value;
            REG_DIRECTION: rdata_q[NPINS-1:0] <= dir_q;
            REG_OPTION: rdata_q[NPINS-1:0] <= opt_q;
            REG_SENSITIVITY: rdata_q[SENS_BITS-1:0] <= sens_q;
            REG_NONE: rresp_q <= RESP_SLVERR;
         endcase
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule

// [gpio_port_chk.sv]
// checker for the gpio port pins, bus answers and interrupt requests
`timescale 1ns/10ps
module gpio_port_chk
   import gpio_port_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [gpio_port_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // pads and peripherals
   input wire logic [gpio_port_pkg::PINS-1:0] pad_in,
   input wire logic [gpio_port_pkg::PINS-1:0] pad_out,
   input wire logic [gpio_port_pkg::PINS-1:0] pad_oe,
   input wire logic [gpio_port_pkg::PINS-1:0] pad_pullup_en,
   input wire logic [gpio_port_pkg::PINS-1:0] alt_out_en,
   input wire logic [gpio_port_pkg::PINS-1:0] alt_out_val,
   input wire logic [gpio_port_pkg::PINS-1:0] alt_open_drain,
   // interrupts
   input wire logic [gpio_port_pkg::GROUPS-1:0] irq_vector_fetch,
   input wire logic [gpio_port_pkg::GROUPS-1:0] irq_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_alt_push_pull: assert property ((alt_out_en & ~alt_open_drain & ~pad_oe) == 0 &&
      (alt_out_en & ~alt_open_drain & (pad_out ^ alt_out_val)) == 0) else $error("alt push-pull");
   a_alt_open_drain: assert property ((alt_out_en & alt_open_drain &
      (pad_out | ~(pad_oe ^ alt_out_val))) == 0) else $error("alt open-drain");
   a_alt_no_pullup: assert property ((alt_out_en & pad_pullup_en) == 0)
      else $error("pull-up on alt pin");
   a_pull_not_driven: assert property ((pad_oe & pad_pullup_en) == 0)
      else $error("pull-up on driven pin");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_write_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr[11:4] != 0 |-> ##2 s_axi_bvalid
      && s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
   a_fetch_clears: assert property (irq_vector_fetch[0] && (pad_in[3:0] & $past(pad_in[3:0])
      & $past(pad_in[3:0], 2) & $past(pad_in[3:0], 3)) == 4'hf |=> !irq_req[0])
      else $error("request kept after fetch");
   a_reset_idle: assert property ($rose(rst_n) && alt_out_en == 0 |-> pad_oe == 0
      && pad_pullup_en == 0 && irq_req == 0) else $error("pins not idle after reset");
   c_irq: cover property ($rose(irq_req[1]));
   c_alt: cover property (alt_out_en != 0 && alt_open_drain != 0);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_bresp_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind gpio_port gpio_port_chk u_chk (.*);

// [board_model.sv]
// board circuitry on the port pins: drivers, pull-ups and floating lines
`timescale 1ns/10ps
module board_model (
   // clock
   input wire logic clk,
   // pads from the port
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup_en,
   // board drivers
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   // levels seen by the port
   output logic [7:0] pad_in
);
   logic [7:0] last_q = 8'h00;
   // an undriven line drifts, so show the inverse of its last level
   assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_en & ext_val
      | ~ext_en & (pad_pullup_en | ~last_q));
   always @(posedge clk)
      last_q <= pad_in;
endmodule

// [tb_gpio_port.sv]
// testbench for the gpio port
`timescale 1ns/10ps
module tb_gpio_port;
   import gpio_port_pkg::*;
   logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, irq_vector_fetch, irq_req;
   logic [7:0] pad_in, pad_out, pad_oe, pad_pullup_en, alt_out_en, alt_out_val, alt_open_drain;
   logic [7:0] alt_in, ext_en, ext_val, lf, d, o, v, x, a, p, q;
   int bad_count = 0, n_checks = 0, cyc = 0;
   gpio_port DUT (.*);
   board_model board (.*);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // whole run is well under this many cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count = bad_count + 1;
         report_and_stop();
      end
   end
   function automatic logic [7:0] rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction
   function automatic logic [7:0] exp_oe();
      return a & ~(p & q) | ~a & d & (o | ~v);
   endfunction
   function automatic logic [7:0] exp_out();
      return a & ~p & q | ~a & d & o & v;
   endfunction
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] e);
      n_checks++;
      if (seen !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   // handshakes judged at the falling edge, where every ready has settled
   task automatic wr(input logic [11:0] ad, input logic [7:0] dt, input logic [3:0] st,
                     input logic [1:0] er);
      logic pa, pw, pb, pv;
      pb = 1'b0;
      s_axi_awaddr <= ad;
      s_axi_wdata <= {24'h0, dt};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // bready only follows bvalid, so every response must stand a cycle
      while (!pb)
      begin
         @(negedge clk);
         pa = s_axi_awvalid & s_axi_awready;
         pw = s_axi_wvalid & s_axi_wready;
         pv = s_axi_bvalid;
         pb = s_axi_bvalid & s_axi_bready;
         if (pb)
            chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
         @(posedge clk);
         if (pa)
            s_axi_awvalid <= 1'b0;
         if (pw)
            s_axi_wvalid <= 1'b0;
         if (pv && !pb)
            s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] ad, input logic [31:0] e, input logic [1:0] er);
      logic pa, pr, pv;
      pr = 1'b0;
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      while (!pr)
      begin
         @(negedge clk);
         pa = s_axi_arvalid & s_axi_arready;
         pv = s_axi_rvalid;
         pr = s_axi_rvalid & s_axi_rready;
         if (pr)
         begin
            chk("rdata", s_axi_rdata, e);
            chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
         end
         @(posedge clk);
         if (pa)
            s_axi_arvalid <= 1'b0;
         if (pv && !pr)
            s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
   endtask
   initial
   begin
      rst_n = 1'b0;
      lf = 8'h63;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
      {alt_out_en, alt_out_val, alt_open_drain, ext_en, ext_val, irq_vector_fetch} = '0;
      w(5);
      rst_n <= 1'b1;
      w(1);
      rc(DIRECTION_OFS, 0, RESP_OKAY);
      rc(OPTION_OFS, 0, RESP_OKAY);
      rc(SENSITIVITY_OFS, {28'h0, SENS_RESET, SENS_RESET}, RESP_OKAY);
      rc(12'h010, 0, RESP_SLVERR);
      wr(12'h010, 8'hff, 4'hf, RESP_SLVERR);
      wr(DIRECTION_OFS, 8'hff, 4'h0, RESP_OKAY);
      rc(DIRECTION_OFS, 0, RESP_OKAY);
      repeat (24)
      begin
         d = rnd();
         o = rnd();
         v = rnd();
         x = rnd();
         a = rnd() & rnd() & ~(~d & o);
         p = rnd();
         q = rnd();
         alt_out_en <= a;
         alt_open_drain <= p;
         alt_out_val <= q;
         ext_en <= ~d & ~a;
         ext_val <= x;
         wr(PIN_VALUE_OFS, v, 4'h1, RESP_OKAY);
         wr(DIRECTION_OFS, d, 4'h1, RESP_OKAY);
         wr(OPTION_OFS, o, 4'h1, RESP_OKAY);
         w(3);
         chk("pad_oe", pad_oe, exp_oe());
         chk("pad_out", pad_out, exp_out());
         chk("pullup", pad_pullup_en, ~a & ~d & o);
         chk("alt_in", alt_in & ~a, (d & v | ~d & x) & ~a);
         rc(PIN_VALUE_OFS, d & v | ~d & a & q | ~d & ~a & x, RESP_OKAY);
         rc(DIRECTION_OFS, d, RESP_OKAY);
      end
      alt_out_en <= 8'h00;
      ext_en <= 8'hff;
      ext_val <= 8'hff;
      wr(DIRECTION_OFS, 8'h00, 4'h1, RESP_OKAY);
      wr(OPTION_OFS, 8'h11, 4'h1, RESP_OKAY);
      for (int m = 0; m < 4; m++)
      begin
         wr(SENSITIVITY_OFS, {4'h0, m[1:0], m[1:0]}, 4'h1, RESP_OKAY);
         w(4);
         chk("irq", irq_req, 2'b00);
         ext_val <= 8'hef;
         w(4);
         chk("irq", irq_req, {m != 1, 1'b0});
         irq_vector_fetch <= 2'b11;
         w(1);
         irq_vector_fetch <= 2'b00;
         w(4);
         chk("irq", irq_req, {m == 0, 1'b0});
         ext_val <= 8'hff;
         w(4);
         chk("irq", irq_req, {m != 2, 1'b0});
      end
      report_and_stop();
   end
endmodule
